// *** core/ocp_defs.vh ***
// Constants for the four-stage phase overcurrent block
`ifndef OCP_DEFS_VH
`define OCP_DEFS_VH

// ********************************************************
// Timing
// ********************************************************
`define OCP_CLK_PERIOD_PS 5000
`define OCP_BASE_MS       5
`define OCP_BASE_CYCLES   ((`OCP_BASE_MS * 1000000) / (`OCP_CLK_PERIOD_PS / 1000))
`define OCP_REL_MS        60
`define OCP_REL_TICKS     (`OCP_REL_MS / `OCP_BASE_MS)
`define OCP_RESET_PCT     23'h61
`define OCP_FULL_PCT      23'h64

// ********************************************************
// Register offsets (byte addresses)
// ********************************************************
`define OCP_STAGE_STRIDE  8'h20
`define OCP_OFS_CTRL      5'h00
`define OCP_OFS_ISET0     5'h04
`define OCP_OFS_ISET1     5'h08
`define OCP_OFS_OPTIME    5'h0C
`define OCP_OFS_RELTIME   5'h10
`define OCP_OFS_STATUS    5'h14
`define OCP_ADR_IRQ_STAT  8'h80
`define OCP_ADR_IRQ_CLR   8'h84
`define OCP_ADR_IRQ_EN    8'h88

// ********************************************************
// Control register fields
// ********************************************************
`define OCP_F_MODE        2:0
`define OCP_F_MAG         4:3
`define OCP_B_SIDE        5
`define OCP_B_COMM        6
`define OCP_F_FORCE       11:7
`define OCP_B_DLY_EN      12
`define OCP_B_RST_AFTER   13
`define OCP_B_CONTINUE    14
`define OCP_CTRL_W        15

// ********************************************************
// Reset values
// ********************************************************
`define OCP_CTRL_RST      15'h3000
`define OCP_ISET_RST      16'h0078
`define OCP_OPTIME_RST    16'h0028
`define OCP_RELTIME_RST   16'h000C

// ********************************************************
// Encodings
// ********************************************************
`define OCP_MODE_ON       3'h0
`define OCP_MODE_BLK      3'h1
`define OCP_MODE_TEST     3'h2
`define OCP_MODE_TBLK     3'h3
`define OCP_MODE_OFF      3'h4
`define OCP_MAG_RMS       2'h0
`define OCP_MAG_TRMS      2'h1
`define OCP_MAG_PP        2'h2

`endif

// *** core/ocp_stage.v ***
// Four-stage non-directional phase overcurrent block with APB registers
// Operation
// RULE1: Four independent stages, own settings, own state
// RULE2: Magnitude select RMS, TRMS or peak; RMS default
// RULE3: Three phase magnitudes taken every 5 ms
// RULE4: Each phase compared with threshold separately
// RULE5: Common threshold; any phase above picks up
// RULE6: Release only below 97 percent of threshold
// RULE7: Threshold in 0.01 nominal steps, default 1.20
// RULE8: Group select changes thresholds; general settings static
// RULE9: Measurement side 1 or 2, default 1
// RULE10: Comm threshold writes only when permitted
// RULE11: Mode on, blocked, test, test-blocked, off
// RULE12: Global forcing imposes chosen stage status
// RULE13: Real measurements still act while forcing
// RULE14: No delayed release: counter cleared at drop-off
// RULE15: Delayed release, options off: counter frozen
// RULE16: Default 60 ms release, counter held
// RULE17: Continuing counter never trips during release
// RULE18: Start held until release timer expires
// RULE19: Trip when counter reaches operating time
//
// The placing of the registers and the APB slave port are this design's own decisions.
`timescale 1ns/1ps
`default_nettype none
`include "ocp_defs.vh"

module ocp_stage #(
  parameter integer TICK_CYCLES = `OCP_BASE_CYCLES
) (
  // Clock and reset
  input  wire        mclk,
  input  wire        rst_n,
  // APB slave
  input  wire        psel,
  input  wire        penable,
  input  wire        pwrite,
  input  wire [7:0]  paddr,
  input  wire [31:0] pwdata,
  output reg  [31:0] prdata,
  output reg         pready,
  output reg         pslverr,
  // Side 1 phase magnitudes, {C,B,A}, 0.01 x In units
  input  wire [47:0] s1_rms,
  input  wire [47:0] s1_trms,
  input  wire [47:0] s1_pp,
  // Side 2 phase magnitudes
  input  wire [47:0] s2_rms,
  input  wire [47:0] s2_trms,
  input  wire [47:0] s2_pp,
  // Setting group and global test forcing
  input  wire        group_sel,
  input  wire        force_enable,
  // Per-stage blocking inputs
  input  wire [3:0]  block_in,
  // Communication-bus threshold write
  input  wire        comm_wr,
  input  wire [1:0]  comm_stage,
  input  wire [15:0] comm_iset,
  // Stage outputs
  output reg  [3:0]  start_o,
  output reg  [3:0]  trip_o,
  output reg  [3:0]  blocked_o,
  output reg  [11:0] phase_start_o,
  output reg  [11:0] phase_trip_o,
  output reg         irq
);

  // ********************************************************
  // Helper functions
  // ********************************************************
  // Magnitude above the pick-up threshold
  function above;
    input [15:0] m;
    input [15:0] th;
    begin
      above = (m > th);
    end
  endfunction

  // Magnitude below 97 percent of the threshold
  function below_reset;
    input [15:0] m;
    input [15:0] th;
    begin
      below_reset = ({7'h00, m} * `OCP_FULL_PCT) < ({7'h00, th} * `OCP_RESET_PCT); // RULE6
    end
  endfunction

  // Forced status {blocked, trip[2:0], start[2:0]}
  function [6:0] force_dec;
    input [4:0] c;
    begin
      case (c)
        5'h01:   force_dec = 7'h07;
        5'h02:   force_dec = 7'h3F;
        5'h03:   force_dec = 7'h40;
        5'h04:   force_dec = 7'h01;
        5'h05:   force_dec = 7'h02;
        5'h06:   force_dec = 7'h04;
        5'h07:   force_dec = 7'h09;
        5'h08:   force_dec = 7'h12;
        5'h09:   force_dec = 7'h24;
        5'h0A:   force_dec = 7'h03;
        5'h0B:   force_dec = 7'h06;
        5'h0C:   force_dec = 7'h05;
        5'h0D:   force_dec = 7'h07;
        5'h0E:   force_dec = 7'h1B;
        5'h0F:   force_dec = 7'h36;
        5'h10:   force_dec = 7'h2D;
        5'h11:   force_dec = 7'h3F;
        default: force_dec = 7'h00;
      endcase
    end
  endfunction

  // ********************************************************
  // State
  // ********************************************************
  reg [`OCP_CTRL_W-1:0] ctrl_r    [0:3];
  reg [15:0]            iset0_r   [0:3];
  reg [15:0]            iset1_r   [0:3];
  reg [15:0]            optime_r  [0:3];
  reg [15:0]            reltime_r [0:3];
  reg [15:0]            cnt_r     [0:3];
  reg [15:0]            rel_r     [0:3];
  reg [2:0]             pick_r    [0:3];
  reg [3:0]             start_r;
  reg [3:0]             trip_r;
  reg [3:0]             blk_r;
  reg [3:0]             rel_act_r;
  reg [7:0]             irq_stat_r;
  reg [7:0]             irq_en_r;
  reg [31:0]            tick_cnt_r;
  reg                   tick_r;
  reg [15:0]            mag_c     [0:11];
  reg [15:0]            iset_c    [0:3];
  reg [3:0]             f_start_c;
  reg [3:0]             f_trip_c;
  reg [3:0]             f_blk_c;
  reg [11:0]            f_pst_c;
  reg [11:0]            f_ptr_c;
  reg [6:0]             fd;
  reg [47:0]            src;
  reg [31:0]            rdata_c;
  reg                   rerr_c;
  wire                  wr_en;
  wire                  stage_hit;
  wire [1:0]            a_stage;
  wire [4:0]            a_ofs;
  integer               s;
  integer               p;
  integer               i, j, f, w;

  // Address split
  assign a_stage   = paddr[6:5];
  assign a_ofs     = paddr[4:0];
  assign stage_hit = ~paddr[7];
  assign wr_en     = psel & penable & pready & pwrite;

  // ********************************************************
  // 5 ms time base
  // ********************************************************
  // Divider giving one enable pulse per base period
  always @(posedge mclk) begin
    if (!rst_n) begin
      tick_cnt_r <= 32'h0000_0000;
      tick_r     <= 1'b0;
    end else if (tick_cnt_r == TICK_CYCLES - 1) begin
      tick_cnt_r <= 32'h0000_0000;
      tick_r     <= 1'b1; // RULE3
    end else begin
      tick_cnt_r <= tick_cnt_r + 32'h0000_0001;
      tick_r     <= 1'b0;
    end
  end

  // ********************************************************
  // Magnitude and threshold selection
  // ********************************************************
  // Per stage: side, magnitude kind, active setting group
  always @* begin
    src = 48'h0000_0000_0000;
    for (i = 0; i < 4; i = i + 1) begin
      case ({ctrl_r[i][`OCP_B_SIDE], ctrl_r[i][`OCP_F_MAG]}) // RULE2 RULE9
        3'h1:    src = s1_trms;
        3'h2:    src = s1_pp;
        3'h4:    src = s2_rms;
        3'h5:    src = s2_trms;
        3'h6:    src = s2_pp;
        default: src = s1_rms;
      endcase
      for (j = 0; j < 3; j = j + 1) begin
        mag_c[i*3+j] = src[j*16 +: 16];
      end
      iset_c[i] = group_sel ? iset1_r[i] : iset0_r[i]; // RULE8
    end
  end

  // ********************************************************
  // Stage protection logic
  // ********************************************************
  // Pick-up, release timer, operating counter, trip
  always @(posedge mclk) begin
    if (!rst_n) begin
      for (s = 0; s < 4; s = s + 1) begin
        cnt_r[s]  <= 16'h0000;
        rel_r[s]  <= 16'h0000;
        pick_r[s] <= 3'h0;
      end
      start_r   <= 4'h0;
      trip_r    <= 4'h0;
      blk_r     <= 4'h0;
      rel_act_r <= 4'h0;
    end else if (tick_r) begin
      for (s = 0; s < 4; s = s + 1) begin // RULE1
        if (ctrl_r[s][`OCP_F_MODE] == `OCP_MODE_OFF) begin // RULE11
          cnt_r[s]     <= 16'h0000;
          rel_r[s]     <= 16'h0000;
          pick_r[s]    <= 3'h0;
          start_r[s]   <= 1'b0;
          trip_r[s]    <= 1'b0;
          blk_r[s]     <= 1'b0;
          rel_act_r[s] <= 1'b0;
        end else begin
          for (p = 0; p < 3; p = p + 1) begin // RULE4
            if (above(mag_c[s*3+p], iset_c[s]))
              pick_r[s][p] <= 1'b1; // RULE5
            else if (below_reset(mag_c[s*3+p], iset_c[s]))
              pick_r[s][p] <= 1'b0; // RULE6
          end
          blk_r[s] <= (|pick_r[s]) & (block_in[s] | ctrl_r[s][`OCP_F_MODE] == `OCP_MODE_BLK |
                      ctrl_r[s][`OCP_F_MODE] == `OCP_MODE_TBLK); // RULE11
          if ((|pick_r[s]) & ~block_in[s] & ctrl_r[s][`OCP_F_MODE] != `OCP_MODE_BLK &
              ctrl_r[s][`OCP_F_MODE] != `OCP_MODE_TBLK) begin
            // Active pick-up: count toward operating time
            start_r[s]   <= 1'b1;
            rel_act_r[s] <= 1'b0;
            rel_r[s]     <= 16'h0000;
            if (cnt_r[s] != 16'hFFFF)
              cnt_r[s] <= cnt_r[s] + 16'h0001;
            if (cnt_r[s] + 16'h0001 >= optime_r[s])
              trip_r[s] <= 1'b1; // RULE19
          end else begin
            trip_r[s] <= 1'b0; // RULE17
            if (!ctrl_r[s][`OCP_B_DLY_EN]) begin
              cnt_r[s]     <= 16'h0000; // RULE14
              start_r[s]   <= 1'b0;
              rel_act_r[s] <= 1'b0;
            end else if (start_r[s] | rel_act_r[s]) begin
              rel_act_r[s] <= 1'b1;
              if (rel_r[s] + 16'h0001 >= reltime_r[s]) begin
                // Release time over: drop start, clear counter
                start_r[s]   <= 1'b0; // RULE18
                rel_act_r[s] <= 1'b0;
                rel_r[s]     <= 16'h0000;
                cnt_r[s]     <= 16'h0000;
              end else begin
                rel_r[s] <= rel_r[s] + 16'h0001; // RULE16
                if (ctrl_r[s][`OCP_B_CONTINUE] & cnt_r[s] != 16'hFFFF)
                  cnt_r[s] <= cnt_r[s] + 16'h0001; // RULE17
                else
                  cnt_r[s] <= cnt_r[s]; // RULE15
              end
            end
          end
        end
      end
    end
  end

  // ********************************************************
  // Forcing merge
  // ********************************************************
  // Forced status ORed with real status
  always @* begin
    f_start_c = 4'h0;
    f_trip_c  = 4'h0;
    f_blk_c   = 4'h0;
    f_pst_c   = 12'h000;
    f_ptr_c   = 12'h000;
    fd        = 7'h00;
    for (f = 0; f < 4; f = f + 1) begin
      fd = force_enable ? force_dec(ctrl_r[f][`OCP_F_FORCE]) : 7'h00; // RULE12
      f_pst_c[f*3 +: 3] = (start_r[f] ? pick_r[f] : 3'h0) | fd[2:0]; // RULE13
      f_ptr_c[f*3 +: 3] = (trip_r[f] ? pick_r[f] : 3'h0) | fd[5:3];
      f_start_c[f] = start_r[f] | (|fd[2:0]);
      f_trip_c[f]  = trip_r[f] | (|fd[5:3]);
      f_blk_c[f]   = blk_r[f] | fd[6];
    end
  end

  // Registered stage outputs and interrupt line
  always @(posedge mclk) begin
    if (!rst_n) begin
      start_o       <= 4'h0;
      trip_o        <= 4'h0;
      blocked_o     <= 4'h0;
      phase_start_o <= 12'h000;
      phase_trip_o  <= 12'h000;
      irq           <= 1'b0;
    end else begin
      start_o       <= f_start_c;
      trip_o        <= f_trip_c;
      blocked_o     <= f_blk_c;
      phase_start_o <= f_pst_c;
      phase_trip_o  <= f_ptr_c;
      irq           <= |(irq_stat_r & irq_en_r);
    end
  end

  // ********************************************************
  // Interrupt status
  // ********************************************************
  // Rising start/trip set sticky bits; set beats clear
  always @(posedge mclk) begin
    if (!rst_n) begin
      irq_stat_r <= 8'h00;
    end else begin
      irq_stat_r <= (irq_stat_r & ~((wr_en & paddr == `OCP_ADR_IRQ_CLR) ? pwdata[7:0] : 8'h00))
                    | {f_trip_c & ~trip_o, f_start_c & ~start_o};
    end
  end

  // ********************************************************
  // APB register file
  // ********************************************************
  // Read decode
  always @* begin
    rdata_c = 32'h0000_0000;
    rerr_c  = 1'b0;
    if (stage_hit) begin
      case (a_ofs)
        `OCP_OFS_CTRL:    rdata_c = {17'h0_0000, ctrl_r[a_stage]};
        `OCP_OFS_ISET0:   rdata_c = {16'h0000, iset0_r[a_stage]};
        `OCP_OFS_ISET1:   rdata_c = {16'h0000, iset1_r[a_stage]};
        `OCP_OFS_OPTIME:  rdata_c = {16'h0000, optime_r[a_stage]};
        `OCP_OFS_RELTIME: rdata_c = {16'h0000, reltime_r[a_stage]};
        `OCP_OFS_STATUS:  rdata_c = {cnt_r[a_stage], 7'h00, blocked_o[a_stage],
                                     phase_trip_o[a_stage*3 +: 3],
                                     phase_start_o[a_stage*3 +: 3],
                                     trip_o[a_stage], start_o[a_stage]};
        default:          rerr_c  = 1'b1;
      endcase
    end else begin
      case (paddr)
        `OCP_ADR_IRQ_STAT: rdata_c = {24'h00_0000, irq_stat_r};
        `OCP_ADR_IRQ_CLR:  rdata_c = 32'h0000_0000;
        `OCP_ADR_IRQ_EN:   rdata_c = {24'h00_0000, irq_en_r};
        default:           rerr_c  = 1'b1;
      endcase
    end
  end

  // Zero-wait-state answer, read data captured with pready
  always @(posedge mclk) begin
    if (!rst_n) begin
      pready  <= 1'b0;
      prdata  <= 32'h0000_0000;
      pslverr <= 1'b0;
    end else begin
      pready  <= psel & ~penable & ~pready;
      prdata  <= (psel & ~penable & ~pwrite) ? rdata_c : 32'h0000_0000;
      pslverr <= psel & ~penable & rerr_c;
    end
  end

  // Register writes; APB wins over comm-bus threshold write
  always @(posedge mclk) begin
    if (!rst_n) begin
      for (w = 0; w < 4; w = w + 1) begin
        ctrl_r[w]    <= `OCP_CTRL_RST;
        iset0_r[w]   <= `OCP_ISET_RST; // RULE7
        iset1_r[w]   <= `OCP_ISET_RST;
        optime_r[w]  <= `OCP_OPTIME_RST;
        reltime_r[w] <= `OCP_RELTIME_RST; // RULE16
      end
      irq_en_r <= 8'h00;
    end else if (wr_en) begin
      if (stage_hit) begin
        case (a_ofs)
          `OCP_OFS_CTRL:    ctrl_r[a_stage]    <= pwdata[`OCP_CTRL_W-1:0];
          `OCP_OFS_ISET0:   iset0_r[a_stage]   <= pwdata[15:0];
          `OCP_OFS_ISET1:   iset1_r[a_stage]   <= pwdata[15:0];
          `OCP_OFS_OPTIME:  optime_r[a_stage]  <= pwdata[15:0];
          `OCP_OFS_RELTIME: reltime_r[a_stage] <= pwdata[15:0];
          default:          ;
        endcase
      end else if (paddr == `OCP_ADR_IRQ_EN) begin
        irq_en_r <= pwdata[7:0];
      end
    end else if (comm_wr & ctrl_r[comm_stage][`OCP_B_COMM]) begin // RULE10
      if (group_sel)
        iset1_r[comm_stage] <= comm_iset;
      else
        iset0_r[comm_stage] <= comm_iset;
    end
  end

endmodule // ocp_stage
`default_nettype wire

// *** verification/ocp_stage_assertions.sv ***
// Port checker for the four-stage overcurrent block
`timescale 1ns/1ps
`default_nettype none
module ocp_chk (
  // Clock and reset
  input wire logic        mclk,
  input wire logic        rst_n,
  // APB slave side
  input wire logic        psel,
  input wire logic        penable,
  input wire logic [7:0]  paddr,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        pslverr,
  // Stage outputs
  input wire logic [3:0]  start_o,
  input wire logic [3:0]  trip_o,
  input wire logic [11:0] phase_start_o,
  input wire logic [11:0] phase_trip_o
);
  // ****************
  // Helpers
  // ****************
  wire logic setup;
  wire logic hole;
  // Setup phase and decoded unmapped word
  assign setup = psel && !penable;
  assign hole  = paddr >= 8'h8C || (paddr < 8'h80 && paddr[4:0] >= 5'h18);
  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (!rst_n);
  // ****************
  // Properties
  // ****************
  a_reset_quiet: assert property (@(posedge mclk) disable iff (1'b0)
    !rst_n |=> start_o == 4'h0 && trip_o == 4'h0 && !pready)
    else $error("outputs active after reset");
  a_setup_ready: assert property (setup |=> pready ##1 !pready)
    else $error("ready not a single pulse after setup");
  a_ready_cause: assert property (pready |-> $past(setup))
    else $error("ready without setup");
  a_err_ready: assert property (pslverr |-> pready)
    else $error("error outside ready");
  a_idle_zero: assert property (!pready |-> prdata == 32'h0)
    else $error("read data outside ready");
  a_hole_err: assert property (setup && hole |=> pslverr && prdata == 32'h0)
    else $error("unmapped word not refused");
  a_trip_start: assert property ((trip_o & ~start_o) == 4'h0)
    else $error("trip without start");
  a_ptrip_pstart: assert property ((phase_trip_o & ~phase_start_o) == 12'h000)
    else $error("phase trip without phase start");
endmodule // ocp_chk

bind ocp_stage ocp_chk i_chk (
  .mclk(mclk), .rst_n(rst_n), .psel(psel), .penable(penable), .paddr(paddr),
  .prdata(prdata), .pready(pready), .pslverr(pslverr), .start_o(start_o),
  .trip_o(trip_o), .phase_start_o(phase_start_o), .phase_trip_o(phase_trip_o)
);
`default_nettype wire

// *** verification/ocp_meas_model.sv ***
// Measurement front end model driving one chosen magnitude source
`timescale 1ns/1ps
`default_nettype none
module ocp_meas_model (
  // Clock and source choice
  input  wire logic        mclk,
  input  wire logic [2:0]  src,
  input  wire logic [47:0] mag,
  // Six sources: side 1 RMS, TRMS, PP, then side 2
  output var  logic [47:0] m [6]
);
  // Fresh three-phase set every cycle; other sources read zero
  always @(posedge mclk) begin
    for (int i = 0; i < 6; i++) m[i] <= (i == src) ? mag : 48'h0;
  end
endmodule // ocp_meas_model
`default_nettype wire

// *** verification/tb_top.sv ***
// Self-checking bench for the four-stage overcurrent block
`timescale 1ns/1ps
`default_nettype none
`include "ocp_defs.vh"
module tb_top;
  localparam int         TC = 20;
  localparam logic [7:0] CT = `OCP_OFS_CTRL;
  // ****************
  // Signals
  // ****************
  logic        mclk, rst_n, psel, penable, pwrite, pready, pslverr, irq;
  logic        group_sel, force_enable, comm_wr, er;
  logic [1:0]  comm_stage;
  logic [2:0]  src;
  logic [3:0]  block_in, start_o, trip_o, blocked_o;
  logic [7:0]  paddr;
  logic [11:0] phase_start_o, phase_trip_o;
  logic [15:0] comm_iset, hold;
  logic [31:0] pwdata, prdata, rd;
  logic [47:0] mag;
  logic [47:0] m [6];
  int          n_fail, check_count, k;
  wire logic [8:0] fv = {phase_trip_o[2:0], phase_start_o[2:0], blocked_o[0], trip_o[0],
                         start_o[0]};
  // Magnitudes {C,B,A} beside expected {phase starts, stage starts}
  logic [63:0] rows [7] = '{64'h0, 64'h0000_0000_0079_0011, 64'h0000_0079_0075_0031,
    64'h0000_0075_0074_0021, 64'h0078_0000_0000_0000, 64'h0079_0000_0000_0041, 64'h0};
  // Force code, mask and expected forced view
  logic [31:0] frc [4] = '{32'h02_007_003, 32'h03_004_004, 32'h11_1F8_1F8, 32'h04_038_028};
  // ****************
  // Instances
  // ****************
  ocp_meas_model i_meas (.mclk(mclk), .src(src), .mag(mag), .m(m));
  ocp_stage #(.TICK_CYCLES(TC)) i_dut (
    .mclk(mclk), .rst_n(rst_n), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .s1_rms(m[0]), .s1_trms(m[1]), .s1_pp(m[2]), .s2_rms(m[3]), .s2_trms(m[4]),
    .s2_pp(m[5]), .group_sel(group_sel), .force_enable(force_enable),
    .block_in(block_in), .comm_wr(comm_wr), .comm_stage(comm_stage),
    .comm_iset(comm_iset), .start_o(start_o), .trip_o(trip_o), .blocked_o(blocked_o),
    .phase_start_o(phase_start_o), .phase_trip_o(phase_trip_o), .irq(irq)
  );
  // 200 MHz clock
  initial begin
    mclk = 1'b0;
    forever #2.5 mclk = ~mclk;
  end
  // ****************
  // Tasks
  // ****************
  task automatic give_verdict;
    $display("checks %0d mismatches %0d", check_count, n_fail);
    if (n_fail == 0 && check_count > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      n_fail++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // One APB transfer, held until ready is sampled high
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int j;
    @(posedge mclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge mclk);
    penable <= 1'b1;
    for (j = 0; j < 8; j++) begin
      @(posedge mclk);
      if (pready === 1'b1) break;
    end
    if (j == 8) begin
      n_fail++;
      give_verdict();
    end
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask
  task automatic rdc(input logic [7:0] a, input logic [31:0] e);
    apb(1'b0, a, 32'h0);
    chk(rd, e);
  endtask
  task automatic wt(input int n);
    repeat (n * TC) @(posedge mclk);
  endtask
  // Bounded wait for stage 0 start
  task automatic wst;
    int j;
    for (j = 0; j < 4 * TC; j++) begin
      @(posedge mclk);
      if (start_o[0] === 1'b1) break;
    end
    if (j == 4 * TC) begin
      n_fail++;
      give_verdict();
    end
  endtask
  // Write, let the interrupt flop follow, compare the line
  task automatic wirq(input logic [7:0] a, input logic [31:0] d, input logic v);
    wr(a, d);
    repeat (2) @(posedge mclk);
    chk(32'(irq), 32'(v));
  endtask
  task automatic cw(input logic [15:0] v);
    @(posedge mclk);
    comm_iset <= v;
    comm_wr <= 1'b1;
    @(posedge mclk);
    comm_wr <= 1'b0;
  endtask
  // ****************
  // Sequence
  // ****************
  initial begin
    {psel, penable, pwrite, group_sel, force_enable, comm_wr, er} = 7'h00;
    {paddr, pwdata, block_in, comm_stage, comm_iset, src, mag} = 113'h0;
    {n_fail, check_count} = 64'h0;
    rst_n = 1'b0;
    repeat (10) @(posedge mclk);
    rst_n <= 1'b1;
    @(posedge mclk);
    chk(32'({start_o, trip_o, blocked_o, irq}), 32'h0);
    rdc(CT, 32'h0000_3000);
    rdc(`OCP_OFS_ISET0, 32'h0000_0078);
    rdc(`OCP_OFS_RELTIME, 32'h0000_000C);
    rdc(8'h9C, 32'h0);
    chk(32'(er), 32'h1);
    // Stage 1 high threshold, stages 2 and 3 off, stage 0 instant release
    wr(8'h24, 32'h0000_01F4);
    wr(8'h40, 32'h4);
    wr(8'h60, 32'h4);
    wr(CT, 32'h0);
    for (k = 0; k < 7; k++) begin
      mag <= rows[k][63:16];
      wt(2);
      chk(32'({phase_start_o[2:0], start_o}), 32'(rows[k][6:0]));
    end
    // Trip at operating time; interrupt raised, masked and cleared
    wr(`OCP_OFS_OPTIME, 32'h4);
    wr(`OCP_ADR_IRQ_CLR, 32'hFF);
    wr(`OCP_ADR_IRQ_EN, 32'h11);
    mag <= 48'h79;
    wst();
    wt(2);
    chk(32'(trip_o), 32'h0);
    wt(1);
    chk(32'({phase_trip_o[2:0], trip_o}), 32'h11);
    rdc(`OCP_ADR_IRQ_STAT, 32'h11);
    wirq(`OCP_ADR_IRQ_EN, 32'h0, 1'b0);
    wirq(`OCP_ADR_IRQ_EN, 32'h11, 1'b1);
    wirq(`OCP_ADR_IRQ_CLR, 32'h11, 1'b0);
    mag <= 48'h0;
    wt(2);
    rdc(`OCP_OFS_STATUS, 32'h0);
    // Delayed release holds start and freezes the counter
    wr(`OCP_OFS_OPTIME, 32'h28);
    wr(CT, 32'h1000);
    mag <= 48'h79;
    wt(3);
    mag <= 48'h0;
    wt(2);
    apb(1'b0, `OCP_OFS_STATUS, 32'h0);
    hold = rd[31:16];
    wt(4);
    apb(1'b0, `OCP_OFS_STATUS, 32'h0);
    chk(32'({rd[31:16], rd[0]}), 32'({hold, 1'b1}));
    wt(8);
    chk(32'(start_o[0]), 32'h0);
    // Counting on during release never trips
    wr(`OCP_OFS_OPTIME, 32'h4);
    wr(CT, 32'h5000);
    mag <= 48'h79;
    wst();
    mag <= 48'h0;
    wt(6);
    chk(32'(trip_o[0]), 32'h0);
    wt(8);
    // Every magnitude kind on both sides
    mag <= 48'h79;
    for (k = 0; k < 6; k++) begin
      wr(CT, 32'((k / 3) * 32 + (k % 3) * 8));
      src <= 3'(k);
      // Three periods: two ticks to react whatever the tick phase
      wt(3);
      chk(32'(start_o[0]), 32'h1);
      src <= 3'((k + 1) % 6);
      wt(3);
      chk(32'(start_o[0]), 32'h0);
    end
    // Setting group swaps thresholds, general settings untouched
    wr(CT, 32'h0);
    wr(`OCP_OFS_ISET1, 32'h0000_00C8);
    mag <= 48'h96;
    group_sel <= 1'b1;
    wt(3);
    chk(32'(start_o[0]), 32'h0);
    group_sel <= 1'b0;
    wt(3);
    chk(32'(start_o[0]), 32'h1);
    rdc(CT, 32'h0);
    // Bus threshold writes need permission
    cw(16'h012C);
    rdc(`OCP_OFS_ISET0, 32'h78);
    wr(CT, 32'h40);
    cw(16'h012C);
    rdc(`OCP_OFS_ISET0, 32'h12C);
    // Forced status beside a real fault on phase C
    mag <= 48'h0190_0000_0000;
    force_enable <= 1'b1;
    for (k = 0; k < 4; k++) begin
      wr(CT, {20'h0, frc[k][28:24], 7'h00});
      wt(2);
      chk(32'(fv & frc[k][20:12]), 32'(frc[k][8:0]));
    end
    // Blocking input, then blocked and off modes
    force_enable <= 1'b0;
    wr(CT, 32'h0);
    block_in <= 4'h1;
    wt(2);
    chk(32'({blocked_o[0], start_o[0]}), 32'h2);
    block_in <= 4'h0;
    wr(CT, 32'h1);
    wt(2);
    chk(32'({blocked_o[0], start_o[0]}), 32'h2);
    wr(CT, 32'h3);
    wt(2);
    chk(32'({blocked_o[0], start_o[0]}), 32'h2);
    wr(CT, 32'h4);
    wt(2);
    chk(32'({blocked_o[0], start_o[0], trip_o[0]}), 32'h0);
    give_verdict();
  end
endmodule // tb_top
`default_nettype wire
